/* bench/move_alu_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module move_alu_checker
    import move_alu_pkg::*;
(
    input wire logic              hclk,
    input wire logic              hresetn,
    input wire logic              hreadyout,
    input wire logic              hresp,
    input wire logic              op_valid,
    input wire logic [OPC_W-1:0]  op_word,
    input wire logic [DATA_W-1:0] acc_out,
    input wire logic [DATA_W-1:0] status_out,
    input wire logic              op_done,
    input wire logic              op_ignored
);
    logic              sub;
    logic              known;
    logic [DATA_W-1:0] prev_acc;
    assign sub = op_valid && op_word[11:5] == OPC_SUB;
    assign known = sub || op_valid && op_word[11:5] inside {OPC_NOT, OPC_DEC, OPC_INC};
    always_ff @(posedge hclk) begin
        prev_acc <= acc_out;
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    done_a: assert property (known |=> op_done && !op_ignored)
        else $error("op_done missing");
    pulse_a: assert property (op_done |-> $past(known))
        else $error("op_done without op");
    zero_a: assert property (known |=> status_out[2] == (acc_out == 8'h00))
        else $error("zero flag wrong");
    keep_dc_a: assert property (known && !sub |=> $stable(status_out[1:0]))
        else $error("carry flags changed");
    upper_a: assert property (known |=> $stable(status_out[7:3]))
        else $error("upper status changed");
    // with carry set no borrow-in applies, so the old acc plus the result gives the operand
    sub_c_a: assert property (sub && status_out[0] |=>
        status_out[0] == (9'(acc_out) + 9'(prev_acc) < 9'h100)) else $error("carry wrong");
    sub_dc_a: assert property (sub && status_out[0] |=>
        status_out[1] == (5'(acc_out[3:0]) + 5'(prev_acc[3:0]) < 5'h10))
        else $error("digit flag wrong");
    okay_a: assert property (!hresp && hreadyout)
        else $error("bus response wrong");
    ignore_a: assert property (op_valid && !known |=> op_ignored && !op_done)
        else $error("op_ignored missing");
    idle_a: assert property (!op_valid |=> !op_done && !op_ignored)
        else $error("pulse without op");
endmodule
bind move_alu_top move_alu_checker checker_u (.hclk, .hresetn, .hreadyout, .hresp,
    .op_valid, .op_word, .acc_out, .status_out, .op_done, .op_ignored);
`default_nettype wire

/* bench/op_issuer.sv */
`timescale 1ns/10ps
`default_nettype none
module op_issuer
    import move_alu_pkg::*;
(
    input wire logic         hclk,
    output logic             op_valid,
    output logic [OPC_W-1:0] op_word
);
    initial begin
        op_valid = 1'b0;
        op_word = '0;
    end
    // holds one opcode for n edges, then shows its inverse so stale data is not trusted
    task automatic issue(input logic [OPC_W-1:0] w, input int n);
        op_valid <= 1'b1;
        op_word <= w;
        repeat (n) @(posedge hclk);
        op_valid <= 1'b0;
        op_word <= ~w;
    endtask
endmodule
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
    import move_alu_pkg::*;
    logic              hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic              op_valid, op_done, op_ignored;
    logic [31:0]       haddr, hwdata, hrdata;
    logic [1:0]        htrans;
    logic [2:0]        hsize;
    logic [OPC_W-1:0]  op_word;
    logic [DATA_W-1:0] acc_out, status_out;
    int                failures, samples_checked;
    // fuse, status, acc, opcode, expected acc, expected status
    localparam logic [44:0] CASES [10] = '{
        {1'h1, 8'h03, 8'h00, 12'h003, 8'h8a, 8'h03},
        {1'h1, 8'h00, 8'h11, 12'h002, 8'h00, 8'h04},
        {1'h1, 8'hf8, 8'h06, 12'h084, 8'h2f, 8'hf9},
        {1'h1, 8'h01, 8'h36, 12'h084, 8'hff, 8'h00},
        {1'h0, 8'h00, 8'h06, 12'h084, 8'h2e, 8'h01},
        {1'h0, 8'h01, 8'h35, 12'h084, 8'h00, 8'h07},
        {1'h1, 8'h02, 8'h00, 12'h0c1, 8'h00, 8'h06},
        {1'h1, 8'h05, 8'h00, 12'h0c3, 8'h74, 8'h01},
        {1'h1, 8'h01, 8'h00, 12'h282, 8'h00, 8'h05},
        {1'h1, 8'h06, 8'h00, 12'h283, 8'h76, 8'h02}};
    move_alu_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .op_valid, .op_word, .acc_out,
        .status_out, .op_done, .op_ignored);
    op_issuer issuer_u (.hclk, .op_valid, .op_word);
    function automatic logic [31:0] fa(input int i);
        return 32'(FILE_BASE) + 32'(4 * i);
    endfunction
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic bw(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask
    task automatic br(input string name, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        chk(name, exp, r);
    endtask
    task automatic run(input logic [11:0] w, input int n, input logic [7:0] ea,
                       input logic [7:0] es);
        issuer_u.issue(w, n);
        #1;
        chk("op_done", 32'h1, 32'(op_done));
        chk("acc", 32'(ea), 32'(acc_out));
        chk("status", 32'(es), 32'(status_out));
        @(posedge hclk);
    endtask
    task automatic summarize();
        if (failures == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    initial begin
        repeat (5000) @(posedge hclk);
        failures++;
        summarize();
    end
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        failures = 0;
        samples_checked = 0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        br("config", 32'(REG_CONFIG), 32'h1);
        bw(fa(1), 32'h01);
        bw(fa(2), 32'hff);
        bw(fa(3), 32'h75);
        bw(fa(4), 32'h35);
        foreach (CASES[k]) begin
            bw(32'(REG_CONFIG), 32'(CASES[k][44]));
            bw(32'(REG_STATUS), 32'(CASES[k][43:36]));
            bw(32'(REG_ACC), 32'(CASES[k][35:28]));
            run(CASES[k][27:16], 1, CASES[k][15:8], CASES[k][7:0]);
        end
        bw(32'(REG_CONFIG), 32'h1);
        bw(32'(REG_STATUS), 32'h1);
        bw(32'(REG_ACC), 32'h6);
        run(12'h084, 2, 8'h06, 8'h01);
        issuer_u.issue(12'hfff, 1);
        #1;
        chk("op_ignored", 32'h1, 32'(op_ignored));
        chk("acc kept", 32'h6, 32'(acc_out));
        chk("status kept", 32'h1, 32'(status_out));
        @(posedge hclk);
        br("last_op", 32'(REG_LAST_OP), 32'h0fff);
        br("op_count", 32'(REG_OP_COUNT), 32'hc);
        br("unmapped", 32'h40, 32'h0);
        br("file 3", fa(3), 32'h75);
        br("file 4", fa(4), 32'h35);
        br("acc bus", 32'(REG_ACC), 32'h06);
        br("status bus", 32'(REG_STATUS), 32'h01);
        // a bus write to acc lands at the same edge as an instruction: the instruction wins
        fork
            bw(32'(REG_ACC), 32'h55);
            begin
                @(posedge hclk);
                issuer_u.issue(12'h003, 1);
            end
        join
        #1;
        chk("acc over bus", 32'h8a, 32'(acc_out));
        chk("status over bus", 32'h1, 32'(status_out));
        @(posedge hclk);
        bw(32'(REG_OP_COUNT), 32'h0);
        br("count clear", 32'(REG_OP_COUNT), 32'h0);
        // second reset in mid-run brings back the reset values
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("acc reset", 32'h0, 32'(acc_out));
        chk("status reset", 32'h0, 32'(status_out));
        br("config reset", 32'(REG_CONFIG), 32'h1);
        br("file reset", fa(3), 32'h0);
        summarize();
    end
endmodule
`default_nettype wire

/* logic/exec_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface exec_if;
    import move_alu_pkg::*;

    logic [OPC_W-1:0]   opcode;
    op_kind_t           kind;
    logic [FILE_AW-1:0] addr;
    logic [DATA_W-1:0]  operand;
    logic [DATA_W-1:0]  acc;
    logic [DATA_W-1:0]  status;
    logic               borrow_en;
    logic [DATA_W-1:0]  result;
    logic [DATA_W-1:0]  next_status;

    modport decoder (input opcode, output kind, output addr);
    modport alu (input kind, input operand, input acc, input status, input borrow_en,
                 output result, output next_status);
    modport core (output opcode, output operand, output acc, output status,
                  output borrow_en, input kind, input addr, input result, input next_status);
endinterface
`default_nettype wire

/* logic/move_alu.sv */
`timescale 1ns/10ps
`default_nettype none
module move_alu
    import move_alu_pkg::*;
(
    exec_if.alu ex
);
    logic       borrow_in;
    logic [8:0] diff;
    logic [4:0] nibble_diff;

    always_comb begin
        borrow_in   = ex.borrow_en & ~ex.status[STATUS_C_BIT];
        diff        = {1'h0, ex.operand} - {1'h0, ex.acc} - {8'h00, borrow_in};
        nibble_diff = {1'h0, ex.operand[3:0]} - {1'h0, ex.acc[3:0]} - {4'h0, borrow_in};
        ex.result      = ex.acc;
        ex.next_status = ex.status;
        case (ex.kind)
            OP_NOT: begin
                ex.result = ~ex.operand;
                ex.next_status[STATUS_Z_BIT] = (ex.result == 8'h00);
            end
            OP_SUB: begin
                ex.result = diff[7:0];
                // only carry, digit borrow and zero move
                ex.next_status[STATUS_C_BIT]  = ~diff[8];
                ex.next_status[STATUS_DC_BIT] = ~nibble_diff[4];
                ex.next_status[STATUS_Z_BIT]  = (diff[7:0] == 8'h00);
            end
            OP_DEC: begin
                ex.result = ex.operand - 8'h01;
                ex.next_status[STATUS_Z_BIT] = (ex.operand == 8'h01);
            end
            OP_INC: begin
                ex.result = ex.operand + 8'h01;
                ex.next_status[STATUS_Z_BIT] = (ex.operand == 8'hff);
            end
            default: begin
                ex.result      = ex.acc;
                ex.next_status = ex.status;
            end
        endcase
    end
endmodule
`default_nettype wire

/* logic/move_alu_pkg.sv */
// How it works
// - complement opcode loads inverted file operand
// - complement sets zero flag on 00h result
// - subtract opcode loads operand minus accumulator
// - carry cleared on borrow, else set
// - digit borrow flag cleared on nibble borrow
// - subtract sets zero flag on 00h difference
// - fuse at 0 adds inverted-carry borrow-in
// - subtract touches only carry, digit, zero
// - decrement opcode loads operand minus one
// - decrement zero flag set only from 01h
// - increment opcode loads operand plus one
// - increment wraps FFh to 00h, sets zero
package move_alu_pkg;

    localparam int DATA_W     = 8;
    localparam int OPC_W      = 12;
    localparam int FILE_AW    = 5;
    localparam int FILE_DEPTH = 32;

    // opcode bits 11..5 select the instruction, bits 4..0 the file register
    localparam logic [6:0] OPC_NOT = 7'h00;
    localparam logic [6:0] OPC_SUB = 7'h04;
    localparam logic [6:0] OPC_DEC = 7'h06;
    localparam logic [6:0] OPC_INC = 7'h14;

    // byte offsets on the bus
    localparam logic [7:0] REG_ACC      = 8'h00;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_CONFIG   = 8'h08;
    localparam logic [7:0] REG_LAST_OP  = 8'h0c;
    localparam logic [7:0] REG_OP_COUNT = 8'h10;
    localparam logic [7:0] FILE_BASE    = 8'h80;

    // field positions
    localparam int STATUS_C_BIT      = 0;
    localparam int STATUS_DC_BIT     = 1;
    localparam int STATUS_Z_BIT      = 2;
    localparam int CONFIG_FUSE_BIT   = 0;
    localparam int LAST_OP_KNOWN_BIT = 16;

    // reset values
    localparam logic [7:0]  ACC_RESET    = 8'h00;
    localparam logic [7:0]  STATUS_RESET = 8'h00;
    localparam logic        FUSE_RESET   = 1'h1;
    localparam logic [7:0]  FILE_RESET   = 8'h00;
    localparam logic [15:0] COUNT_RESET  = 16'h0000;
    localparam logic [15:0] COUNT_ONE    = 16'h0001;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_NOT,
        OP_SUB,
        OP_DEC,
        OP_INC
    } op_kind_t;

endpackage

/* logic/move_alu_top.sv */
`timescale 1ns/10ps
`default_nettype none
module move_alu_top
    import move_alu_pkg::*;
(
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic              op_valid,
    input  wire logic [OPC_W-1:0]  op_word,
    output logic [DATA_W-1:0]      acc_out,
    output logic [DATA_W-1:0]      status_out,
    output logic                   op_done,
    output logic                   op_ignored
);

    exec_if ex ();

    logic [DATA_W-1:0]  acc;
    logic [DATA_W-1:0]  status;
    logic               carry_in_fuse_bit;
    logic [OPC_W-1:0]   last_op;
    logic               last_op_known;
    logic [15:0]        op_count;
    logic [DATA_W-1:0]  file_operand [FILE_DEPTH];

    logic               accept;
    logic               addr_ok;
    logic               wr_pend;
    logic [7:0]         wr_addr;
    logic               wr_acc;
    logic               wr_status;
    logic               wr_config;
    logic               wr_count;
    logic               wr_file;
    logic               fwd;
    logic               exec_go;
    logic [31:0]        rd_word;
    logic [31:0]        wr_view;

    op_decode u_decode (
        .ex (ex.decoder)
    );

    move_alu u_alu (
        .ex (ex.alu)
    );

    // instruction side
    assign ex.opcode    = op_word;
    assign ex.operand   = file_operand[ex.addr];
    assign ex.acc       = acc;
    assign ex.status    = status;
    // an unprogrammed fuse reads 1, so borrow-in is off after reset
    assign ex.borrow_en = ~carry_in_fuse_bit;

    assign exec_go = op_valid & (ex.kind != OP_NONE);

    // bus address phase
    assign accept  = hsel & htrans[1] & hready;
    assign addr_ok = (haddr[31:8] == 24'h000000) & (haddr[1:0] == 2'h0) &
                     (hsize == 3'h2);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'h0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= accept & hwrite & addr_ok;
            wr_addr <= haddr[7:0];
        end
    end

    // bus data phase write decode
    assign wr_acc    = wr_pend & (wr_addr == REG_ACC);
    assign wr_status = wr_pend & (wr_addr == REG_STATUS);
    assign wr_config = wr_pend & (wr_addr == REG_CONFIG);
    assign wr_count  = wr_pend & (wr_addr == REG_OP_COUNT);
    assign wr_file   = wr_pend & wr_addr[7];

    // accumulator: an instruction in the same cycle wins over the bus
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc <= ACC_RESET;
        end else if (exec_go) begin
            acc <= ex.result;
        end else if (wr_acc) begin
            acc <= hwdata[DATA_W-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status <= STATUS_RESET;
        end else if (exec_go) begin
            status <= ex.next_status;
        end else if (wr_status) begin
            status <= hwdata[DATA_W-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            carry_in_fuse_bit <= FUSE_RESET;
        end else if (wr_config) begin
            carry_in_fuse_bit <= hwdata[CONFIG_FUSE_BIT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_op       <= {OPC_W{1'h0}};
            last_op_known <= 1'h0;
        end else if (op_valid) begin
            last_op       <= op_word;
            last_op_known <= exec_go;
        end
    end

    // a count in the same cycle as a clear survives the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            op_count <= COUNT_RESET;
        end else if (wr_count) begin
            op_count <= exec_go ? COUNT_ONE : COUNT_RESET;
        end else if (exec_go) begin
            op_count <= op_count + COUNT_ONE;
        end
    end

    // file registers: written only by the bus, never by an instruction
    generate
        for (genvar i = 0; i < FILE_DEPTH; i++) begin : g_file
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    file_operand[i] <= FILE_RESET;
                end else if (wr_file && (wr_addr[6:2] == FILE_AW'(i))) begin
                    file_operand[i] <= hwdata[DATA_W-1:0];
                end
            end
        end
    endgenerate

    // a read right after a write to the same word sees the new value, except at the op count
    assign fwd     = wr_pend & (wr_addr == haddr[7:0]);
    assign wr_view = {24'h000000, hwdata[DATA_W-1:0]};

    always_comb begin
        rd_word = 32'h00000000;
        if (addr_ok) begin
            if (haddr[7]) begin
                rd_word = fwd ? wr_view : {24'h000000, file_operand[haddr[6:2]]};
            end else begin
                case (haddr[7:0])
                    REG_ACC: begin
                        rd_word = fwd ? wr_view : {24'h000000, acc};
                    end
                    REG_STATUS: begin
                        rd_word = fwd ? wr_view : {24'h000000, status};
                    end
                    REG_CONFIG: begin
                        rd_word = {31'h00000000,
                                   fwd ? hwdata[CONFIG_FUSE_BIT] : carry_in_fuse_bit};
                    end
                    REG_LAST_OP: begin
                        rd_word = {15'h0000, last_op_known, 4'h0, last_op};
                    end
                    REG_OP_COUNT: begin
                        rd_word = {16'h0000, op_count};
                    end
                    default: begin
                        rd_word = 32'h00000000;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (accept && !hwrite) begin
            hrdata <= rd_word;
        end else begin
            hrdata <= 32'h00000000;
        end
    end

    // zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'h1;
            hresp     <= 1'h0;
        end else begin
            hreadyout <= 1'h1;
            hresp     <= 1'h0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            op_done    <= 1'h0;
            op_ignored <= 1'h0;
        end else begin
            op_done    <= exec_go;
            op_ignored <= op_valid & ~exec_go;
        end
    end

    assign acc_out    = acc;
    assign status_out = status;

endmodule
`default_nettype wire

/* logic/op_decode.sv */
`timescale 1ns/10ps
`default_nettype none
module op_decode
    import move_alu_pkg::*;
(
    exec_if.decoder ex
);
    always_comb begin
        ex.addr = ex.opcode[FILE_AW-1:0];
        case (ex.opcode[OPC_W-1:FILE_AW])
            OPC_NOT: ex.kind = OP_NOT;
            OPC_SUB: ex.kind = OP_SUB;
            OPC_DEC: ex.kind = OP_DEC;
            OPC_INC: ex.kind = OP_INC;
            default: ex.kind = OP_NONE;
        endcase
    end
endmodule
`default_nettype wire
